// ===== hw/sxs_pkg.sv
// Purpose: constants and types of the signal-extension state unit
// Assumes: one core clock, one asynchronous active-low reset
// Notes: field positions follow the control register layout
package sxs_pkg;
	// ***********************************************************
	// control register layout
	// ***********************************************************
	localparam int CTL_W = 32;
	localparam int CCOND_HI = 27;
	localparam int CCOND_LO = 24;
	localparam int OUF_HI = 23;
	localparam int OUF_LO = 16;
	localparam int EFI_BIT = 14;
	localparam int CARRY_BIT = 13;
	localparam int FIELD_SIZE_COUNT_HI = 12;
	localparam int FIELD_SIZE_COUNT_LO = 7;
	localparam int POS_HI = 5;
	localparam int POS_LO = 0;
	localparam logic [31:0] CTL_RW_MASK = 32'h0fff_7fbf;
	localparam logic [31:0] CTL_RESET = 32'h0000_0000;
	// ***********************************************************
	// flag indices inside the overflow field
	// ***********************************************************
	localparam int OUF_ARITH = 4;
	localparam int OUF_MUL = 5;
	localparam int OUF_SHIFT = 6;
	localparam int OUF_EXTR = 7;
	// ***********************************************************
	// misc constants
	// ***********************************************************
	localparam logic [4:0] EXC_CAUSE_DISABLED = 5'h1a;
	localparam logic [5:0] POS_LHI_STEP = 6'h20;
	localparam logic [1:0] PRESENT_RESET = 2'h3;
	localparam int NUM_ACC = 4;
	localparam int ACC_W = 64;
	localparam int WORD_W = 32;
	localparam int BYTE_W = 8;
	localparam int HALF_W = 16;
	typedef enum logic [2:0] {
		SXS_OUF_MAC,
		SXS_OUF_ARITH,
		SXS_OUF_MUL,
		SXS_OUF_SHIFT,
		SXS_OUF_EXTR
	} sxs_ouf_class_t;
	typedef enum logic [1:0] {
		SXS_CMP_SCALAR,
		SXS_CMP_PAIR,
		SXS_CMP_QUAD
	} sxs_cmp_width_t;
endpackage

// ===== hw/sxs_state_unit.sv
// Purpose: extension state, accumulators and status update logic
// Assumes: pipeline strobes are one-cycle pulses on sys_clk
// Notes: all outputs registered
//
// Overview of operation
// - vector ops use two halves or four bytes
// - byte lanes unsigned, half lanes signed
// - both presence bits always read one
// - disabled extension raises exception cause 26
// - four 64-bit accumulators, index 0 legacy
// - 32-bit control, only via control instructions
// - reserved bits written zero, read undefined
// - compare bits reset zero, narrow compares low
// - overflow sets flag, except carry, acc shift
// - overflow flags sticky until software write
// - mac overflow sets bit 16 plus acc
// - arith sets bit 20, multiply bit 21
// - shift/precision bit 22, acc extract bit 23
// - every extract rewrites fail bit 14
// - carry bit written by add, consumed
// - size at 12:7, position at 5:0
// - position lowest for insert, highest extract
// - decrementing extract subtracts length from position
// - low-to-high insert copies lo, position plus 32
module sxs_state_unit (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic ext_enable_bit,
	input wire logic acc_move,
	input wire logic ctl_rd,
	input wire logic ctl_wr,
	input wire logic [31:0] ctl_wr_data,
	input wire logic cmp_valid,
	input wire sxs_pkg::sxs_cmp_width_t cmp_width,
	input wire logic [3:0] cmp_result,
	input wire logic ovf_valid,
	input wire sxs_pkg::sxs_ouf_class_t ovf_class,
	input wire logic carry_wr,
	input wire logic carry_in,
	input wire logic ext_valid,
	input wire logic ext_decrement,
	input wire logic [5:0] ext_size,
	input wire logic lhi_valid,
	input wire logic [1:0] acc_sel,
	input wire logic acc_wr,
	input wire logic [63:0] acc_wr_data,
	input wire logic acc_rd,
	input wire logic simd_valid,
	input wire logic simd_quad,
	input wire logic simd_sub,
	input wire logic [31:0] simd_a,
	input wire logic [31:0] simd_b,
	output logic [31:0] signal_ext_control_reg,
	output logic [31:0] ctl_rd_data_reg,
	output logic [63:0] acc_rd_data_reg,
	output logic [31:0] simd_result_reg,
	output logic [1:0] ext_present_bit_reg,
	output logic disabled_exc_reg,
	output logic [4:0] exc_cause_reg
);
	// ***********************************************************
	// issue gating
	// ***********************************************************
	logic any_ext;
	logic ok;
	assign any_ext = acc_move | ctl_rd | ctl_wr | cmp_valid | ovf_valid
		| carry_wr | ext_valid | lhi_valid | acc_wr | acc_rd
		| simd_valid;
	assign ok = ext_enable_bit;

	// ***********************************************************
	// packed lane arithmetic
	// ***********************************************************
	logic [8:0] byte_sum [4];
	logic [16:0] half_sum [2];
	logic [3:0] byte_ovf;
	logic [1:0] half_ovf;
	logic [31:0] simd_next;
	logic simd_ovf;
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_lane
			logic [8:0] ua;
			logic [8:0] ub;
			assign ua = {1'b0, simd_a[g*sxs_pkg::BYTE_W +: 8]};
			assign ub = {1'b0, simd_b[g*sxs_pkg::BYTE_W +: 8]};
			assign byte_sum[g] = simd_sub ? ua - ub : ua + ub;
			assign byte_ovf[g] = byte_sum[g][8];
			if (g < 2) begin : g_half
				logic [16:0] sa;
				logic [16:0] sb;
				logic [15:0] ha;
				logic [15:0] hb;
				assign ha = simd_a[g*sxs_pkg::HALF_W +: 16];
				assign hb = simd_b[g*sxs_pkg::HALF_W +: 16];
				assign sa = {ha[15], ha};
				assign sb = {hb[15], hb};
				assign half_sum[g] = simd_sub ? sa - sb : sa + sb;
				assign half_ovf[g] = half_sum[g][16] ^ half_sum[g][15];
			end
		end
	endgenerate
	always_comb begin
		if (simd_quad) begin
			simd_next = {byte_sum[3][7:0], byte_sum[2][7:0],
				byte_sum[1][7:0], byte_sum[0][7:0]};
			simd_ovf = |byte_ovf;
		end else begin
			simd_next = {half_sum[1][15:0], half_sum[0][15:0]};
			simd_ovf = |half_ovf;
		end
	end

	// ***********************************************************
	// overflow flag sources
	// ***********************************************************
	logic [7:0] ouf_set;
	always_comb begin
		ouf_set = 8'h00;
		if (ovf_valid && ok) begin
			case (ovf_class)
				sxs_pkg::SXS_OUF_MAC: ouf_set[acc_sel] = 1'b1;
				sxs_pkg::SXS_OUF_ARITH: ouf_set[sxs_pkg::OUF_ARITH] = 1'b1;
				sxs_pkg::SXS_OUF_MUL: ouf_set[sxs_pkg::OUF_MUL] = 1'b1;
				sxs_pkg::SXS_OUF_SHIFT: ouf_set[sxs_pkg::OUF_SHIFT] = 1'b1;
				sxs_pkg::SXS_OUF_EXTR: ouf_set[sxs_pkg::OUF_EXTR] = 1'b1;
				default: ouf_set = 8'h00;
			endcase
		end
		if (simd_valid && ok && simd_ovf) begin
			ouf_set[sxs_pkg::OUF_ARITH] = 1'b1;
		end
	end

	// ***********************************************************
	// control register
	// ***********************************************************
	logic [31:0] ctl_reg;
	logic [31:0] ctl_next;
	logic [5:0] pos_cur;
	assign pos_cur = ctl_reg[sxs_pkg::POS_HI:sxs_pkg::POS_LO];
	always_comb begin
		ctl_next = ctl_reg;
		if (ctl_wr && ok) begin
			ctl_next = ctl_wr_data & sxs_pkg::CTL_RW_MASK;
		end
		if (cmp_valid && ok) begin
			case (cmp_width)
				sxs_pkg::SXS_CMP_SCALAR:
					ctl_next[sxs_pkg::CCOND_LO] = cmp_result[0];
				sxs_pkg::SXS_CMP_PAIR:
					ctl_next[sxs_pkg::CCOND_LO +: 2] = cmp_result[1:0];
				sxs_pkg::SXS_CMP_QUAD:
					ctl_next[sxs_pkg::CCOND_HI:sxs_pkg::CCOND_LO] = cmp_result;
				default: ;
			endcase
		end
		if (carry_wr && ok) begin
			ctl_next[sxs_pkg::CARRY_BIT] = carry_in;
		end
		if (ext_valid && ok) begin
			// position marks the highest bit of an extract
			ctl_next[sxs_pkg::EFI_BIT] = pos_cur < ext_size;
			if (ext_decrement) begin
				ctl_next[sxs_pkg::POS_HI:sxs_pkg::POS_LO] =
					pos_cur - ext_size;
			end
		end
		if (lhi_valid && ok) begin
			ctl_next[sxs_pkg::POS_HI:sxs_pkg::POS_LO] =
				pos_cur + sxs_pkg::POS_LHI_STEP;
		end
		// hardware set wins over a software clear
		ctl_next[sxs_pkg::OUF_HI:sxs_pkg::OUF_LO] =
			ctl_next[sxs_pkg::OUF_HI:sxs_pkg::OUF_LO] | ouf_set;
	end
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			ctl_reg <= sxs_pkg::CTL_RESET;
		end else begin
			ctl_reg <= ctl_next;
		end
	end
	assign signal_ext_control_reg = ctl_reg;

	// ***********************************************************
	// accumulators
	// ***********************************************************
	logic [63:0] acc_reg [sxs_pkg::NUM_ACC];
	logic [63:0] acc_next [sxs_pkg::NUM_ACC];
	always_comb begin
		for (int i = 0; i < sxs_pkg::NUM_ACC; i++) begin
			acc_next[i] = acc_reg[i];
		end
		if (acc_wr && ok) begin
			acc_next[acc_sel] = acc_wr_data;
		end
		if (lhi_valid && ok) begin
			acc_next[acc_sel][63:32] = acc_reg[acc_sel][31:0];
		end
	end
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < sxs_pkg::NUM_ACC; i++) begin
				acc_reg[i] <= 64'h0;
			end
		end else begin
			for (int i = 0; i < sxs_pkg::NUM_ACC; i++) begin
				acc_reg[i] <= acc_next[i];
			end
		end
	end

	// ***********************************************************
	// registered outputs
	// ***********************************************************
	logic [31:0] ctl_rd_next;
	logic [63:0] acc_rd_next;
	logic [31:0] simd_res_next;
	logic exc_next;
	logic [4:0] cause_next;
	always_comb begin
		ctl_rd_next = ctl_rd_data_reg;
		acc_rd_next = acc_rd_data_reg;
		simd_res_next = simd_result_reg;
		if (ctl_rd && ok) begin
			ctl_rd_next = ctl_reg;
		end
		if (acc_rd && ok) begin
			acc_rd_next = acc_reg[acc_sel];
		end
		if (simd_valid && ok) begin
			simd_res_next = simd_next;
		end
		exc_next = any_ext && !ok;
		cause_next = exc_next ? sxs_pkg::EXC_CAUSE_DISABLED : 5'h00;
	end
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			ctl_rd_data_reg <= 32'h0;
			acc_rd_data_reg <= 64'h0;
			simd_result_reg <= 32'h0;
			disabled_exc_reg <= 1'b0;
			exc_cause_reg <= 5'h00;
			ext_present_bit_reg <= sxs_pkg::PRESENT_RESET;
		end else begin
			ctl_rd_data_reg <= ctl_rd_next;
			acc_rd_data_reg <= acc_rd_next;
			simd_result_reg <= simd_res_next;
			disabled_exc_reg <= exc_next;
			exc_cause_reg <= cause_next;
			ext_present_bit_reg <= sxs_pkg::PRESENT_RESET;
		end
	end

	// ***********************************************************
	// checks
	// ***********************************************************
	a_reserved_zero: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		(ctl_reg & ~sxs_pkg::CTL_RW_MASK) == 32'h0)
		else $error("reserved control bits not zero");
	a_exc_cause: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		(any_ext && !ext_enable_bit) |=> disabled_exc_reg
		&& exc_cause_reg == sxs_pkg::EXC_CAUSE_DISABLED)
		else $error("disabled extension not trapped");
	a_disabled_hold: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		!ext_enable_bit |=> $stable(ctl_reg))
		else $error("control changed while disabled");
	a_ouf_sticky: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		(!ctl_wr && ctl_reg[sxs_pkg::OUF_LO + sxs_pkg::OUF_ARITH])
		|=> ctl_reg[sxs_pkg::OUF_LO + sxs_pkg::OUF_ARITH])
		else $error("overflow flag cleared without write");
	a_mac_flag: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		(ovf_valid && ext_enable_bit && ovf_class == sxs_pkg::SXS_OUF_MAC)
		|=> ctl_reg[sxs_pkg::OUF_LO + $past(acc_sel)])
		else $error("mac overflow flag not set");
	a_efi_value: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		(ext_valid && ext_enable_bit && !lhi_valid)
		|=> ctl_reg[sxs_pkg::EFI_BIT] == ($past(pos_cur) < $past(ext_size)))
		else $error("extract fail bit wrong");
	a_pos_decrement: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		(ext_valid && ext_decrement && ext_enable_bit && !ctl_wr
		&& !lhi_valid)
		|=> pos_cur == 6'($past(pos_cur) - $past(ext_size)))
		else $error("position not decremented");
	a_lhi_pos: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		(lhi_valid && ext_enable_bit && !ctl_wr)
		|=> pos_cur == 6'($past(pos_cur) + sxs_pkg::POS_LHI_STEP))
		else $error("position not advanced by 32");
	a_present_one: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		ext_present_bit_reg == sxs_pkg::PRESENT_RESET)
		else $error("presence bits not set");
	a_carry_write: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		(carry_wr && ext_enable_bit)
		|=> ctl_reg[sxs_pkg::CARRY_BIT] == $past(carry_in))
		else $error("carry bit not written");
endmodule

// ===== dv/sxs_pipe_model.sv
// Purpose: pipeline side holder of the extension enable level
// Assumes: a new level lands one core edge after the request
// Notes: behavioural partner, resets to disabled
module sxs_pipe_model (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic en_req,
	output logic ext_enable_bit
);
	timeunit 1ns;
	timeprecision 1ps;
	// ***************************************************
	// status enable level
	// ***************************************************
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			ext_enable_bit <= 1'b0;
		else
			ext_enable_bit <= en_req;
	end
endmodule

// ===== dv/testbench.sv
// Purpose: self-checking bench of the extension state unit
// Assumes: one strobe per issue (acc_move also rides with acc_wr or ctl_wr), one idle cycle between issues
// Notes: reference kept in m_ctl and m_acc
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0, resetn = 1'b0, en_req = 1'b1, ext_enable_bit;
	logic acc_move, ctl_rd, ctl_wr, cmp_valid, ovf_valid, carry_wr;
	logic carry_in, ext_valid, ext_decrement, lhi_valid, acc_wr, acc_rd;
	logic simd_valid, simd_quad, simd_sub, disabled_exc_reg, m_exc, o;
	logic [31:0] ctl_wr_data, simd_a, simd_b, signal_ext_control_reg;
	logic [31:0] ctl_rd_data_reg, simd_result_reg, m_ctl, a, b, r;
	logic [31:0] seed = 32'hbac1;
	logic [63:0] acc_wr_data, acc_rd_data_reg, v;
	logic [63:0] m_acc [4];
	logic [5:0] ext_size, p, s;
	logic [3:0] cmp_result, m;
	logic [1:0] acc_sel, ext_present_bit_reg;
	logic [4:0] exc_cause_reg;
	sxs_pkg::sxs_cmp_width_t cmp_width;
	sxs_pkg::sxs_ouf_class_t ovf_class;
	int n_mismatch, checks, cyc, x, y, t;
	sxs_pipe_model pipe (.sys_clk, .resetn, .en_req, .ext_enable_bit);
	sxs_state_unit uut (
		.sys_clk, .resetn, .ext_enable_bit, .acc_move, .ctl_rd, .ctl_wr,
		.ctl_wr_data, .cmp_valid, .cmp_width, .cmp_result, .ovf_valid,
		.ovf_class, .carry_wr, .carry_in, .ext_valid, .ext_decrement,
		.ext_size, .lhi_valid, .acc_sel, .acc_wr, .acc_wr_data, .acc_rd,
		.simd_valid, .simd_quad, .simd_sub, .simd_a, .simd_b,
		.signal_ext_control_reg, .ctl_rd_data_reg, .acc_rd_data_reg,
		.simd_result_reg, .ext_present_bit_reg, .disabled_exc_reg,
		.exc_cause_reg
	);
	// ***************************************************
	// helpers
	// ***************************************************
	always #10 sys_clk = ~sys_clk;
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic idle();
		{acc_move, ctl_rd, ctl_wr, cmp_valid, ovf_valid, carry_wr} <= '0;
		{ext_valid, lhi_valid, acc_wr, acc_rd, simd_valid} <= '0;
	endtask
	task automatic step();
		@(posedge sys_clk);
		idle();
		#1;
		chk(signal_ext_control_reg, m_ctl);
		chk(disabled_exc_reg, m_exc);
		chk(exc_cause_reg, m_exc ? 5'h1a : 5'h00);
		m_exc = 1'b0;
	endtask
	task automatic wr_ctl(input logic [31:0] d);
		@(posedge sys_clk);
		ctl_wr <= 1'b1;
		ctl_wr_data <= d & 32'h0fff_7fbf;
		m_ctl = d & 32'h0fff_7fbf;
		step();
	endtask
	task automatic rd_acc(input int k);
		@(posedge sys_clk);
		acc_rd <= 1'b1;
		acc_sel <= 2'(k);
		step();
		chk(acc_rd_data_reg, m_acc[k]);
	endtask
	task automatic set_en(input logic e);
		@(posedge sys_clk);
		en_req <= e;
		@(posedge sys_clk);
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			wrap_up();
		end
	end
	// ***************************************************
	// tests
	// ***************************************************
	initial begin
		idle();
		{ctl_wr_data, simd_a, simd_b, acc_wr_data, ext_size} <= '0;
		{ext_decrement, carry_in, cmp_result, acc_sel} <= '0;
		{simd_quad, simd_sub} <= '0;
		cmp_width <= sxs_pkg::SXS_CMP_SCALAR;
		ovf_class <= sxs_pkg::SXS_OUF_MAC;
		m_ctl = 32'h0;
		m_exc = 1'b0;
		m_acc = '{default: 64'h0};
		repeat (6) @(posedge sys_clk);
		resetn <= 1'b1;
		#1;
		chk(signal_ext_control_reg, 32'h0);
		chk(ext_present_bit_reg, 2'h3);
		for (int k = 0; k < 4; k++) rd_acc(k);
		$display("test reset done");
		repeat (4) begin
			wr_ctl(rnd());
			@(posedge sys_clk);
			ctl_rd <= 1'b1;
			step();
			chk(ctl_rd_data_reg, m_ctl);
		end
		$display("test control done");
		for (int k = 0; k < 4; k++) begin
			v = {rnd(), rnd()};
			@(posedge sys_clk);
			{acc_wr, acc_move} <= 2'b11;
			acc_sel <= 2'(k);
			acc_wr_data <= v;
			m_acc[k] = v;
			step();
		end
		for (int k = 3; k >= 0; k--) rd_acc(k);
		$display("test accumulators done");
		for (int i = 0; i < 9; i++) begin
			v = 64'(rnd());
			m = i % 3 == 0 ? 4'h1 : (i % 3 == 1 ? 4'h3 : 4'hf);
			@(posedge sys_clk);
			cmp_valid <= 1'b1;
			cmp_width <= sxs_pkg::sxs_cmp_width_t'(i % 3);
			cmp_result <= v[3:0];
			m_ctl[27:24] = (m_ctl[27:24] & ~m) | (v[3:0] & m);
			step();
		end
		$display("test compare done");
		for (int c = 0; c < 8; c++) begin
			@(posedge sys_clk);
			ovf_valid <= 1'b1;
			ovf_class <= sxs_pkg::sxs_ouf_class_t'(c < 4 ? 0 : c - 3);
			acc_sel <= 2'(c);
			m_ctl[16 + c] = 1'b1;
			step();
		end
		for (int c = 0; c < 2; c++) begin
			@(posedge sys_clk);
			carry_wr <= 1'b1;
			carry_in <= 1'(c == 0);
			m_ctl[13] = 1'(c == 0);
			step();
		end
		wr_ctl(32'h0);
		$display("test flags done");
		for (int i = 0; i < 6; i++) begin
			p = 6'(rnd());
			s = i == 0 ? p : 6'(rnd());
			wr_ctl({17'h0, 1'(p >= s), 8'h0, p});
			@(posedge sys_clk);
			ext_valid <= 1'b1;
			ext_size <= s;
			ext_decrement <= 1'(i > 1);
			m_ctl[14] = 1'(p < s);
			if (i > 1) m_ctl[5:0] = p - s;
			step();
		end
		for (int k = 0; k < 4; k++) begin
			@(posedge sys_clk);
			lhi_valid <= 1'b1;
			acc_sel <= 2'(k);
			m_acc[k][63:32] = m_acc[k][31:0];
			m_ctl[5:0] = m_ctl[5:0] + 6'd32;
			step();
			rd_acc(k);
		end
		$display("test extract done");
		for (int i = 0; i < 8; i++) begin
			a = rnd();
			b = rnd();
			r = 32'h0;
			o = 1'b0;
			for (int g = 0; g < 4; g++) begin
				if (i % 2 == 1) begin
					x = a[8*g +: 8];
					y = b[8*g +: 8];
					t = i > 3 ? x - y : x + y;
					o |= t < 0 || t > 255;
					r[8*g +: 8] = t[7:0];
				end else if (g < 2) begin
					x = $signed(a[16*g +: 16]);
					y = $signed(b[16*g +: 16]);
					t = i > 3 ? x - y : x + y;
					o |= t < -32768 || t > 32767;
					r[16*g +: 16] = t[15:0];
				end
			end
			@(posedge sys_clk);
			{simd_valid, simd_a, simd_b} <= {1'b1, a, b};
			simd_quad <= 1'(i % 2);
			simd_sub <= 1'(i > 3);
			if (o) m_ctl[20] = 1'b1;
			step();
			chk(simd_result_reg, r);
		end
		$display("test lanes done");
		set_en(1'b0);
		@(posedge sys_clk);
		{ctl_wr, acc_move} <= 2'b11;
		ctl_wr_data <= 32'h0fff_7fbf;
		m_exc = 1'b1;
		step();
		@(posedge sys_clk);
		acc_rd <= 1'b1;
		acc_sel <= 2'h0;
		m_exc = 1'b1;
		step();
		chk(acc_rd_data_reg, m_acc[3]);
		step();
		$display("test disabled done");
		wrap_up();
	end
endmodule
